/* cim_regs.svh */
`ifndef CIM_REGS_SVH
`define CIM_REGS_SVH

// ==========================================================
// register map (word index on the plain register port)
`define CIM_DIN_BASE 8'h00
`define CIM_VIN_BASE 8'h10
`define CIM_DOUT_BASE 8'h20
`define CIM_USR_BASE 8'h30
`define CIM_STAT_ADDR 8'h40

// ==========================================================
// lane counts
`define CIM_NUM_DIN 10
`define CIM_NUM_VIN 4
`define CIM_NUM_LANE 14
`define CIM_NUM_DOUT 6
`define CIM_NUM_USR 2
`define CIM_NUM_PULSE 4

// ==========================================================
// status word field positions
`define CIM_STAT_DOUT_LSB 0
`define CIM_STAT_USR_LSB 6
`define CIM_STAT_LANE_LSB 8

// ==========================================================
// codes and reset values
`define CIM_CONST_OFF 8'h80
`define CIM_NO_FUNC 7'h00
`define CIM_MAX_MS 8'd250
`define CIM_DIN0_FUNC 7'h20
`define CIM_DIN1_FUNC 7'h40
`define CIM_DIN2_FUNC 7'h41
`define CIM_DIN3_FUNC 7'h42
`define CIM_DIN4_FUNC 7'h25
`define CIM_DIN5_FUNC 7'h01
`define CIM_DIN6_FUNC 7'h05
`define CIM_DIN7_FUNC 7'h08
`define CIM_DIN8_FUNC 7'h30
`define CIM_DIN9_FUNC 7'h31
`define CIM_DOUT0_FUNC 8'h90
`define CIM_DOUT1_FUNC 8'h8a
`define CIM_DOUT2_FUNC 8'h85
`define CIM_DOUT3_FUNC 8'h84
`define CIM_DOUT4_FUNC 8'h86
`define CIM_DOUT5_FUNC 8'h82
`define CIM_DOUT_LOGIC_RST 1'b1
`define CIM_USR_LOGIC_RST 1'b0

// ==========================================================
// timing
`define CIM_CLK_HZ 100000000
`define CIM_TICK_MS 1
`define CIM_ONESHOT_US 250
`define CIM_MS_CYCLES ((`CIM_CLK_HZ / 1000) * `CIM_TICK_MS)
`define CIM_ONESHOT_CYCLES ((`CIM_CLK_HZ / 1000000) * `CIM_ONESHOT_US)

`endif

/* cim_pkg.sv */
package cim_pkg;
    // ======================================================
    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } cim_req_t;

    // ======================================================
    // input lane settings, low 17 bits of the word
    typedef struct packed {
        logic oneshot;
        logic [7:0] dead_ms;
        logic inv;
        logic [6:0] func;
    } cim_in_cfg_t;

    typedef struct packed {
        logic [7:0] src;
        logic [6:0] rsv;
        cim_in_cfg_t lane;
    } cim_vin_cfg_t;

    typedef struct packed {
        logic [4:0] rsv;
        logic comp_inv;
        logic logic_or;
        logic inv;
        logic [7:0] off_ms;
        logic [7:0] comp;
        logic [7:0] func;
    } cim_dout_cfg_t;

    typedef struct packed {
        logic [12:0] rsv;
        logic logic_or;
        logic inv_b;
        logic inv_a;
        logic [7:0] src_b;
        logic [7:0] src_a;
    } cim_usr_cfg_t;
endpackage

/* cim_mapper.sv */
// How it works
// - with composite in use, each output pin shows two internal signals combined.
// - each output inversion swaps ON and OFF of the combined result driving the pin.
// - each output turns OFF only after its source has been OFF past delay.
// - each output chooses AND or OR for its composite combination.
// - each output picks a second signal; pin ON when combination holds.
// - composite inversion swaps ON and OFF of the second signal.
// - each user output combines selectable sources A and B internally.
// - exactly two independent user outputs exist.
// - sources A and B each have their own inversion.
// - each user output selects AND or OR for A and B.
// - ten direct inputs map to function codes with documented defaults.
// - on pulse variants inputs 0 to 3 carry pulses only.
// - input inversion 0 keeps polarity, 1 swaps; default 0.
// - input asserts only after staying ON past dead time 0..250 ms.
// - virtual input asserts its function while its selected source is ON.
// - one-shot input drops back 250 us after assertion.
// - output OFF delay settable 0..250 ms, default 0.
// - composite combination 0 is AND, 1 is OR, default OR.
// - six direct outputs, each with its own full settings.
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "cim_regs.svh"

module cim_mapper #(
    parameter int MS_CYCLES = `CIM_MS_CYCLES,
    parameter int ONESHOT_CYCLES = `CIM_ONESHOT_CYCLES
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire cim_pkg::cim_req_t req,
    output logic [31:0] rdata,
    input wire logic [9:0] din,
    input wire logic [61:1] status_in,
    input wire logic pulse_variant,
    output logic [127:0] func_out,
    output logic [5:0] dout,
    output logic [1:0] internal_user_output,
    output logic [3:0] pulse_in
);
    import cim_pkg::*;

    localparam int MSW = $clog2(MS_CYCLES + 1);
    localparam int OSW = $clog2(ONESHOT_CYCLES + 1);

    // ======================================================
    // helpers
    // codes 0x80..0xbf select an internal output; 0x80 is constant off
    function automatic logic pick(input logic [7:0] code, input logic [63:0] vec);
        pick = (code[7:6] == 2'b10) ? vec[code[5:0]] : 1'b0;
    endfunction

    function automatic logic [7:0] clamp_ms(input logic [7:0] v);
        clamp_ms = (v > `CIM_MAX_MS) ? `CIM_MAX_MS : v;
    endfunction

    function automatic logic combine(input logic a, input logic b, input logic use_or);
        combine = use_or ? (a | b) : (a & b);
    endfunction

    function automatic cim_in_cfg_t din_default(input int i);
        cim_in_cfg_t c;
        c = '0;
        case (i)
            0: c.func = `CIM_DIN0_FUNC;
            1: c.func = `CIM_DIN1_FUNC;
            2: c.func = `CIM_DIN2_FUNC;
            3: c.func = `CIM_DIN3_FUNC;
            4: c.func = `CIM_DIN4_FUNC;
            5: c.func = `CIM_DIN5_FUNC;
            6: c.func = `CIM_DIN6_FUNC;
            7: c.func = `CIM_DIN7_FUNC;
            8: c.func = `CIM_DIN8_FUNC;
            9: c.func = `CIM_DIN9_FUNC;
            default: c.func = `CIM_NO_FUNC;
        endcase
        return c;
    endfunction

    function automatic cim_dout_cfg_t dout_default(input int i);
        cim_dout_cfg_t c;
        c = '0;
        c.comp = `CIM_CONST_OFF;
        c.logic_or = `CIM_DOUT_LOGIC_RST;
        case (i)
            0: c.func = `CIM_DOUT0_FUNC;
            1: c.func = `CIM_DOUT1_FUNC;
            2: c.func = `CIM_DOUT2_FUNC;
            3: c.func = `CIM_DOUT3_FUNC;
            4: c.func = `CIM_DOUT4_FUNC;
            default: c.func = `CIM_DOUT5_FUNC;
        endcase
        return c;
    endfunction

    // ======================================================
    // settings
    cim_in_cfg_t lane_cfg_q [`CIM_NUM_LANE];
    logic [7:0] vin_src_q [`CIM_NUM_VIN];
    cim_dout_cfg_t dout_cfg_q [`CIM_NUM_DOUT];
    cim_usr_cfg_t usr_cfg_q [`CIM_NUM_USR];
    logic pulse_q;
    logic [MSW-1:0] ms_cnt_q;
    logic tick_q;
    logic [7:0] dead_cnt_q [`CIM_NUM_LANE];
    logic [`CIM_NUM_LANE-1:0] filt_q;
    logic [OSW-1:0] shot_cnt_q [`CIM_NUM_LANE];
    logic [7:0] off_cnt_q [`CIM_NUM_DOUT];
    logic [`CIM_NUM_LANE-1:0] lane_raw;
    logic [`CIM_NUM_LANE-1:0] lane_on;
    logic [5:0] dout_comb;
    logic [63:0] src_vec;
    logic [127:0] func_d;

    // user outputs feed back as selectable sources 0xbe and 0xbf
    assign src_vec = {internal_user_output, status_in, 1'b0};

    // ======================================================
    // register writes
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            for (int i = 0; i < `CIM_NUM_LANE; i++) begin
                lane_cfg_q[i] <= din_default(i);
            end
            for (int i = 0; i < `CIM_NUM_VIN; i++) begin
                vin_src_q[i] <= `CIM_CONST_OFF;
            end
            for (int i = 0; i < `CIM_NUM_DOUT; i++) begin
                dout_cfg_q[i] <= dout_default(i);
            end
            for (int i = 0; i < `CIM_NUM_USR; i++) begin
                usr_cfg_q[i] <= '{rsv: '0, logic_or: `CIM_USR_LOGIC_RST, inv_b: 1'b0, inv_a: 1'b0,
                                  src_b: `CIM_CONST_OFF, src_a: `CIM_CONST_OFF};
            end
        end else if (req.wr) begin
            if (req.addr >= `CIM_DIN_BASE && req.addr < `CIM_DIN_BASE + 8'(`CIM_NUM_DIN)) begin
                lane_cfg_q[req.addr[3:0]] <= {req.wdata[16], clamp_ms(req.wdata[15:8]), req.wdata[7:0]};
            end else if (req.addr >= `CIM_VIN_BASE && req.addr < `CIM_VIN_BASE + 8'(`CIM_NUM_VIN)) begin
                lane_cfg_q[4'(`CIM_NUM_DIN) + req.addr[3:0]] <=
                    {req.wdata[16], clamp_ms(req.wdata[15:8]), req.wdata[7:0]};
                vin_src_q[req.addr[1:0]] <= req.wdata[31:24];
            end else if (req.addr >= `CIM_DOUT_BASE && req.addr < `CIM_DOUT_BASE + 8'(`CIM_NUM_DOUT)) begin
                dout_cfg_q[req.addr[2:0]] <= {5'h0, req.wdata[26:24], clamp_ms(req.wdata[23:16]),
                                              req.wdata[15:0]};
            end else if (req.addr >= `CIM_USR_BASE && req.addr < `CIM_USR_BASE + 8'(`CIM_NUM_USR)) begin
                usr_cfg_q[req.addr[0]] <= {13'h0, req.wdata[18:0]};
            end
        end
    end

    // ======================================================
    // register reads, data valid in the next cycle only
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rdata <= '0;
        end else if (!req.rd) begin
            rdata <= '0;
        end else if (req.addr >= `CIM_DIN_BASE && req.addr < `CIM_DIN_BASE + 8'(`CIM_NUM_DIN)) begin
            rdata <= {15'h0, lane_cfg_q[req.addr[3:0]]};
        end else if (req.addr >= `CIM_VIN_BASE && req.addr < `CIM_VIN_BASE + 8'(`CIM_NUM_VIN)) begin
            rdata <= {vin_src_q[req.addr[1:0]], 7'h0, lane_cfg_q[4'(`CIM_NUM_DIN) + req.addr[3:0]]};
        end else if (req.addr >= `CIM_DOUT_BASE && req.addr < `CIM_DOUT_BASE + 8'(`CIM_NUM_DOUT)) begin
            rdata <= dout_cfg_q[req.addr[2:0]];
        end else if (req.addr >= `CIM_USR_BASE && req.addr < `CIM_USR_BASE + 8'(`CIM_NUM_USR)) begin
            rdata <= usr_cfg_q[req.addr[0]];
        end else if (req.addr == `CIM_STAT_ADDR) begin
            rdata <= {10'h0, lane_on, internal_user_output, dout};
        end else begin
            rdata <= '0;
        end
    end

    // ======================================================
    // millisecond timebase
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ms_cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (ms_cnt_q == MSW'(MS_CYCLES - 1));
            ms_cnt_q <= (ms_cnt_q == MSW'(MS_CYCLES - 1)) ? '0 : ms_cnt_q + 1'b1;
        end
    end

    // ======================================================
    // input lanes: invert, dead-time filter, one-shot
    always_comb begin
        for (int i = 0; i < `CIM_NUM_LANE; i++) begin
            if (i < `CIM_NUM_DIN) begin
                lane_raw[i] = din[i] ^ lane_cfg_q[i].inv;
            end else begin
                lane_raw[i] = pick(vin_src_q[i - `CIM_NUM_DIN], src_vec) ^ lane_cfg_q[i].inv;
            end
            lane_on[i] = filt_q[i] & (!lane_cfg_q[i].oneshot || shot_cnt_q[i] != '0);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            filt_q <= '0;
            for (int i = 0; i < `CIM_NUM_LANE; i++) begin
                dead_cnt_q[i] <= '0;
                shot_cnt_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < `CIM_NUM_LANE; i++) begin
                // ON only after the dead time
                if (!lane_raw[i]) begin
                    dead_cnt_q[i] <= '0;
                    filt_q[i] <= 1'b0;
                end else if (dead_cnt_q[i] >= lane_cfg_q[i].dead_ms) begin
                    filt_q[i] <= 1'b1;
                end else if (tick_q) begin
                    dead_cnt_q[i] <= dead_cnt_q[i] + 8'd1;
                end
                if (!filt_q[i]) begin
                    shot_cnt_q[i] <= OSW'(ONESHOT_CYCLES);
                end else if (shot_cnt_q[i] != '0) begin
                    shot_cnt_q[i] <= shot_cnt_q[i] - 1'b1;
                end
            end
        end
    end

    // ======================================================
    // function decode
    always_comb begin
        func_d = '0;
        for (int i = 0; i < `CIM_NUM_LANE; i++) begin
            if (lane_on[i] && lane_cfg_q[i].func != `CIM_NO_FUNC && !(pulse_q && i < `CIM_NUM_PULSE)) begin
                func_d[lane_cfg_q[i].func] = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pulse_q <= 1'b0;
            func_out <= '0;
            pulse_in <= '0;
        end else begin
            pulse_q <= pulse_variant;
            func_out <= func_d;
            // raw pulse pins passed to the pulse counter
            pulse_in <= pulse_q ? din[3:0] : 4'h0;
        end
    end

    // ======================================================
    // direct outputs: combine, invert, OFF delay
    always_comb begin
        for (int i = 0; i < `CIM_NUM_DOUT; i++) begin
            dout_comb[i] = combine(pick(dout_cfg_q[i].func, src_vec),
                                   pick(dout_cfg_q[i].comp, src_vec) ^ dout_cfg_q[i].comp_inv,
                                   dout_cfg_q[i].logic_or) ^ dout_cfg_q[i].inv;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            dout <= '0;
            for (int i = 0; i < `CIM_NUM_DOUT; i++) begin
                off_cnt_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < `CIM_NUM_DOUT; i++) begin
                if (dout_comb[i]) begin
                    dout[i] <= 1'b1;
                    off_cnt_q[i] <= '0;
                end else if (off_cnt_q[i] >= dout_cfg_q[i].off_ms) begin
                    dout[i] <= 1'b0;
                end else if (tick_q) begin
                    off_cnt_q[i] <= off_cnt_q[i] + 8'd1;
                end
            end
        end
    end

    // ======================================================
    // user outputs
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            internal_user_output <= '0;
        end else begin
            for (int i = 0; i < `CIM_NUM_USR; i++) begin
                internal_user_output[i] <= combine(pick(usr_cfg_q[i].src_a, src_vec) ^ usr_cfg_q[i].inv_a,
                                      pick(usr_cfg_q[i].src_b, src_vec) ^ usr_cfg_q[i].inv_b,
                                      usr_cfg_q[i].logic_or);
            end
        end
    end

endmodule // cim_mapper

/* cim_mapper_assertions.sv */
`timescale 1ns/1ps
module cim_mapper_assertions #(
    parameter int MS_CYCLES = 10,
    parameter int ONESHOT_CYCLES = 5
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire cim_pkg::cim_req_t req,
    input wire logic [31:0] rdata,
    input wire logic [9:0] din,
    input wire logic [61:1] status_in,
    input wire logic pulse_variant,
    input wire logic [127:0] func_out,
    input wire logic [5:0] dout,
    input wire logic [1:0] internal_user_output,
    input wire logic [3:0] pulse_in
);
    import cim_pkg::*;
    // ======
    // shadow of output 0 and user output 0 settings
    cim_dout_cfg_t dcfg_q;
    cim_usr_cfg_t ucfg_q;
    logic [1:0] settle_q;
    logic da, db, ua, ub, dexp, uexp, dok, uok;

    // user output codes left out: their own latency is not modelled here
    function automatic logic pick(input logic [7:0] c, input logic [61:1] s);
        pick = (c[7] && c[6:0] != 7'h00 && c[6:0] < 7'h3e) ? s[c[6:0]] : 1'b0;
    endfunction

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            dcfg_q <= 32'h0200_8090;
            ucfg_q <= 32'h0000_8080;
            settle_q <= 2'h0;
        end else begin
            if (req.wr && req.addr == 8'h20) begin
                dcfg_q <= req.wdata;
            end
            if (req.wr && req.addr == 8'h30) begin
                ucfg_q <= req.wdata;
            end
            settle_q <= req.wr ? 2'h0 : settle_q + {1'b0, settle_q != 2'h3};
        end
    end

    assign da = pick(dcfg_q.func, status_in);
    assign db = pick(dcfg_q.comp, status_in) ^ dcfg_q.comp_inv;
    assign dexp = (dcfg_q.logic_or ? (da | db) : (da & db)) ^ dcfg_q.inv;
    assign ua = pick(ucfg_q.src_a, status_in) ^ ucfg_q.inv_a;
    assign ub = pick(ucfg_q.src_b, status_in) ^ ucfg_q.inv_b;
    assign uexp = ucfg_q.logic_or ? (ua | ub) : (ua & ub);
    assign dok = settle_q[1];
    assign uok = settle_q[1];

    // ======
    // properties
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    chk_reset_quiet: assert property ($rose(rstn) |-> dout == 6'h00 && internal_user_output == 2'h0 && ~|func_out)
        else $error("outputs not clear after reset");
    chk_no_func_zero: assert property (func_out[0] == 1'b0)
        else $error("function code zero asserted");
    chk_read_idle: assert property (!req.rd |=> rdata == 32'h0000_0000)
        else $error("read data outside read cycle");
    chk_stat_read: assert property (req.rd && req.addr == 8'h40 |=> rdata[7:0] == $past({internal_user_output, dout}))
        else $error("status word wrong");
    chk_dout_follow: assert property (dok && dcfg_q.off_ms == 8'h00 |-> dout[0] == $past(dexp))
        else $error("output 0 not the combined source");
    chk_dout_on: assert property (dok && $past(dexp) |-> dout[0])
        else $error("output 0 not on with source on");
    chk_dout_cause: assert property (dok && $rose(dout[0]) |-> $past(dexp))
        else $error("output 0 rose without cause");
    chk_usr_follow: assert property (uok |-> internal_user_output[0] == $past(uexp))
        else $error("user output 0 wrong");
    chk_pulse_fwd: assert property ((pulse_variant && $stable(din[3:0]))[*3] |-> pulse_in == din[3:0])
        else $error("pulse pins not forwarded");
    chk_pulse_idle: assert property ((!pulse_variant)[*3] |-> pulse_in == 4'h0)
        else $error("pulse pins forwarded outside variant");

    cover property (dok && $rose(dout[0]));
    cover property (uok && $rose(internal_user_output[0]));
    cover property (req.rd && req.addr == 8'h40);
endmodule // cim_mapper_assertions

bind cim_mapper cim_mapper_assertions #(.MS_CYCLES(MS_CYCLES), .ONESHOT_CYCLES(ONESHOT_CYCLES)) u_chk (
    .mclk(mclk), .rstn(rstn), .req(req), .rdata(rdata), .din(din), .status_in(status_in),
    .pulse_variant(pulse_variant), .func_out(func_out), .dout(dout), .internal_user_output(internal_user_output), .pulse_in(pulse_in));

/* cim_host_model.sv */
`timescale 1ns/1ps
// ======
// host controller: drives the input pins one clock after it is told
module cim_host_model (
    input wire logic mclk,
    input wire logic [9:0] pins_cmd,
    output logic [9:0] din
);
    initial din = 10'h000;
    always @(posedge mclk) begin
        din <= pins_cmd;
    end
endmodule // cim_host_model

/* cim_mapper_tb.sv */
`timescale 1ns/1ps
module cim_mapper_tb;
    import cim_pkg::*;
    localparam int MS = 10;
    localparam int OS = 5;
    logic mclk, rstn, pulse_variant;
    cim_req_t req;
    logic [31:0] rdata, rv;
    logic [9:0] din, pins_cmd;
    logic [61:1] status_in;
    logic [127:0] func_out;
    logic [5:0] dout;
    logic [1:0] internal_user_output;
    logic [3:0] pulse_in;
    int errors, check_count;

    cim_mapper #(.MS_CYCLES(MS), .ONESHOT_CYCLES(OS)) DUT (.mclk(mclk), .rstn(rstn), .req(req), .rdata(rdata),
        .din(din), .status_in(status_in), .pulse_variant(pulse_variant), .func_out(func_out), .dout(dout),
        .internal_user_output(internal_user_output), .pulse_in(pulse_in));
    cim_host_model u_host (.mclk(mclk), .pins_cmd(pins_cmd), .din(din));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ======
    // helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge mclk);
        req.rd <= 1'b0;
        #1;
        rv = rdata;
    endtask

    task automatic st(input int k, input logic v);
        @(posedge mclk);
        status_in[k] <= v;
    endtask

    task automatic pin(input int k, input logic v);
        @(posedge mclk);
        pins_cmd[k] <= v;
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ======
    // scenarios
    task automatic t_defaults();
        logic [6:0] dfn [10] = '{7'h20, 7'h40, 7'h41, 7'h42, 7'h25, 7'h01, 7'h05, 7'h08, 7'h30, 7'h31};
        logic [7:0] ofn [6] = '{8'h90, 8'h8a, 8'h85, 8'h84, 8'h86, 8'h82};
        for (int n = 0; n < 10; n++) begin
            rd(8'(n));
            chk("din cfg", 32'(dfn[n]), {15'h0000, rv[16:0]});
        end
        for (int n = 0; n < 6; n++) begin
            rd(8'h20 + 8'(n));
            chk("dout cfg", {16'h0200, 8'h80, ofn[n]}, {6'h00, rv[25:0]});
        end
        rd(8'h31);
        chk("usr cfg", 32'h0000_8080, {13'h0000, rv[18:0]});
        rd(8'h50);
        chk("unmapped", 32'h0000_0000, rv);
    endtask

    task automatic t_inputs();
        pin(5, 1'b1);
        cyc(5);
        chk("func1 on", 1'b1, 32'(func_out[1]));
        wr(8'h05, 32'h0000_0081);
        pin(5, 1'b0);
        cyc(5);
        chk("func1 inv", 1'b1, 32'(func_out[1]));
        wr(8'h05, 32'h0000_0001);
        wr(8'h06, 32'h0000_ff05);
        rd(8'h06);
        chk("dead clamp", 32'h0000_fa05, {15'h0000, rv[16:0]});
        wr(8'h06, 32'h0000_0305);
        pin(6, 1'b1);
        cyc(2 * MS - 2);
        chk("dead early", 1'b0, 32'(func_out[5]));
        cyc(2 * MS + 8);
        chk("dead late", 1'b1, 32'(func_out[5]));
        wr(8'h07, 32'h0001_0008);
        pin(7, 1'b1);
        cyc(5);
        chk("shot on", 1'b1, 32'(func_out[8]));
        cyc(OS + 6);
        chk("shot off", 1'b0, 32'(func_out[8]));
        wr(8'h10, 32'h8300_0010);
        st(3, 1'b1);
        cyc(5);
        chk("virtual", 1'b1, 32'(func_out[16]));
        st(3, 1'b0);
        @(posedge mclk);
        pins_cmd <= 10'h000;
    endtask

    task automatic t_dout();
        logic a, b, e;
        for (int i = 0; i < 32; i++) begin
            wr(8'h20, {5'h00, i[1], i[0], i[4], 8'h00, 8'h82, 8'h81});
            st(1, i[2]);
            st(2, i[3]);
            cyc(3);
            a = i[2];
            b = i[3] ^ i[1];
            e = (i[0] ? (a | b) : (a & b)) ^ i[4];
            chk("dout combine", 32'(e), 32'(dout[0]));
        end
        @(posedge mclk);
        status_in <= 61'h0;
        for (int n = 0; n < 6; n++) begin
            wr(8'h20 + 8'(n), 32'h0200_8081 + 32'(n));
        end
        for (int k = 1; k < 7; k++) begin
            st(k, 1'b1);
            cyc(3);
            chk("dout lane", 32'(6'h01 << (k - 1)), 32'(dout));
            st(k, 1'b0);
        end
        st(3, 1'b1);
        cyc(3);
        rd(8'h40);
        chk("status", 32'h0000_0004, {24'h00_0000, rv[7:0]});
        st(3, 1'b0);
        wr(8'h20, 32'h02ff_8081);
        rd(8'h20);
        chk("off clamp", 32'h02fa_8081, {6'h00, rv[25:0]});
        wr(8'h20, 32'h0202_8081);
        st(1, 1'b1);
        cyc(3);
        st(1, 1'b0);
        cyc(MS - 3);
        chk("off held", 1'b1, 32'(dout[0]));
        cyc(2 * MS + 6);
        chk("off done", 1'b0, 32'(dout[0]));
        wr(8'h20, 32'h0200_8081);
    endtask

    task automatic t_user();
        logic a, b;
        for (int i = 0; i < 64; i++) begin
            wr(8'h30 + 8'(i[5]), {13'h0000, i[0], i[2], i[1], 8'h84, 8'h83});
            st(3, i[3]);
            st(4, i[4]);
            cyc(3);
            a = i[3] ^ i[1];
            b = i[4] ^ i[2];
            chk("user out", 32'(i[0] ? (a | b) : (a & b)), 32'(internal_user_output[i[5]]));
        end
    endtask

    task automatic t_virtual();
        // user output 0 follows source 3 and feeds virtual input 1; virtual input 2 is
        // forced on by inversion with no function, so code zero must stay clear
        wr(8'h30, 32'h0004_8083);
        wr(8'h11, 32'hbe00_0011);
        wr(8'h12, 32'h8000_0080);
        rd(8'h11);
        chk("vin cfg", 32'hbe00_0011, rv);
        st(3, 1'b1);
        cyc(5);
        chk("vin from user", 1'b1, 32'(func_out[17]));
        rd(8'h40);
        chk("vin lanes", 32'h0000_0003, 32'(rv[20:19]));
        st(3, 1'b0);
        cyc(5);
        chk("vin from user off", 1'b0, 32'(func_out[17]));
    endtask

    task automatic t_pulse();
        @(posedge mclk);
        pulse_variant <= 1'b1;
        pin(0, 1'b1);
        cyc(5);
        chk("pulse func", 1'b0, 32'(func_out[32]));
        chk("pulse pin", 1'b1, 32'(pulse_in[0]));
        @(posedge mclk);
        pulse_variant <= 1'b0;
        cyc(5);
        chk("din0 func", 1'b1, 32'(func_out[32]));
        pin(0, 1'b0);
    endtask

    task automatic t_reset();
        st(1, 1'b1);
        @(posedge mclk);
        rstn <= 1'b0;
        cyc(3);
        chk("reset dout", 32'h0000_0000, 32'(dout));
        @(posedge mclk);
        rstn <= 1'b1;
        rd(8'h20);
        chk("reset cfg", 32'h0200_8090, {6'h00, rv[25:0]});
    endtask

    initial begin
        rstn = 1'b0;
        req = '0;
        status_in = 61'h0;
        pulse_variant = 1'b0;
        pins_cmd = 10'h000;
        errors = 0;
        check_count = 0;
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        t_defaults();
        t_inputs();
        t_dout();
        t_virtual();
        t_user();
        t_pulse();
        t_reset();
        stop_test();
    end

    initial begin
        repeat (30000) @(posedge mclk);
        errors++;
        stop_test();
    end
endmodule // cim_mapper_tb
